//--- tnc_config_regs.v
// thermal and thermistor configuration registers on an APB slave
// assumes: APB master on core_clk, watchdog and register reset
// pulses come from logic on the same clock, comparator pins do not
//
// Chosen here: the APB register port and the placing of the registers.
`include "tnc_regs_map.vh"
`default_nettype none

module tnc_config_regs (
  input  wire        core_clk,
  input  wire        rstn,
  // apb
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // reset sources
  input  wire        wdExpire,
  input  wire        regResetReq,
  // comparator pins: cold, cool, warm, hot
  input  wire        coldCmpPin,
  input  wire        coolCmpPin,
  input  wire        warmCmpPin,
  input  wire        hotCmpPin,
  // configuration and temperature status outputs
  output wire        discharge_overcurrent_enable,
  output wire [1:0]  thermal_regulation_threshold,
  output wire [1:0]  thermal_shutdown_threshold,
  output wire        input_bus_pulldown_enable,
  output wire        adapter1_pulldown_enable,
  output wire        adapter2_pulldown_enable,
  output wire [2:0]  warm_voltage_derate,
  output wire [1:0]  warm_current_derate,
  output wire [1:0]  cool_current_derate,
  output wire [1:0]  cool_comparator_threshold,
  output wire [1:0]  warm_comparator_threshold,
  output wire [1:0]  boost_hot_limit,
  output wire        boost_hot_check_enable,
  output wire        boost_cold_limit,
  output wire        thermistor_bypass,
  output wire        warm_charge_suspend,
  output wire        cool_charge_suspend,
  output wire [3:0]  tempStatus,
  output wire        tempGood,
  output wire        chargeAllow,
  output wire        boostAllow
);

  // ****************************************
  // helpers
  // ****************************************
  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx == `TNC_IDX_BATPROT) || (idx == `TNC_IDX_RSVD) ||
               (idx == `TNC_IDX_THERMAL) || (idx == `TNC_IDX_DERATE) ||
               (idx == `TNC_IDX_THRESH) || (idx == `TNC_IDX_TSTATUS);
    end
  endfunction

  // merge write data into writable bits only
  function [7:0] merge;
    input [7:0] old;
    input [7:0] wdat;
    input [7:0] wmask;
    begin
      merge = (old & ~wmask) | (wdat & wmask);
    end
  endfunction

  // watchdog restores only its own fields
  function [7:0] wdogLoad;
    input [7:0] old;
    input [7:0] def;
    input [7:0] wdmask;
    begin
      wdogLoad = (old & ~wdmask) | (def & wdmask);
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg  [7:0]  batProt_q;
  reg  [7:0]  batProt_d;
  reg  [7:0]  thermal_q;
  reg  [7:0]  thermal_d;
  reg  [7:0]  derate_q;
  reg  [7:0]  derate_d;
  reg  [7:0]  thresh_q;
  reg  [7:0]  thresh_d;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg         pready_q;
  reg         pready_d;
  reg         pslverr_q;
  reg         pslverr_d;
  reg         wSusp_q;
  reg         cSusp_q;
  reg         bhotEn_q;

  wire [5:0]  idx;
  wire        setupPh;
  wire        wrDone;
  wire        lane0;
  wire [7:0]  wbyte;
  wire [3:0]  cmpSync;
  wire [3:0]  statusW;
  wire        goodW;
  wire        chgW;
  wire        boostW;

  assign idx     = paddr[7:2];
  assign setupPh = psel & ~penable;
  assign wrDone  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign lane0   = pstrb[0];
  assign wbyte   = pwdata[7:0];

  // ****************************************
  // comparator pins and status
  // ****************************************
  tnc_sync2 #(
    .W (4)
  ) uSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .asyncIn  ({hotCmpPin, warmCmpPin, coolCmpPin, coldCmpPin}),
    .syncOut  (cmpSync)
  );

  tnc_temp_status uStatus (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .rangeFlags  (cmpSync),
    .bypass      (thresh_q[`TNC_BYPASS_BIT]),
    .tempStatus  (statusW),
    .tempGood    (goodW),
    .chargeAllow (chgW),
    .boostAllow  (boostW)
  );

  // ****************************************
  // register next values
  // ****************************************
  always @* begin
    batProt_d = batProt_q;
    thermal_d = thermal_q;
    derate_d  = derate_q;
    thresh_d  = thresh_q;
    if (regResetReq) begin
      batProt_d = `TNC_RST_BATPROT;
      thermal_d = `TNC_RST_THERMAL;
      derate_d  = `TNC_RST_DERATE;
      thresh_d  = `TNC_RST_THRESH;
    end else if (wdExpire) begin
      batProt_d = wdogLoad(batProt_q, `TNC_RST_BATPROT, `TNC_WDOG_BATPROT);
      thermal_d = wdogLoad(thermal_q, `TNC_RST_THERMAL, `TNC_WDOG_THERMAL);
      derate_d  = wdogLoad(derate_q, `TNC_RST_DERATE, `TNC_WDOG_DERATE);
      thresh_d  = wdogLoad(thresh_q, `TNC_RST_THRESH, `TNC_WDOG_THRESH);
    end else if (wrDone && lane0) begin
      case (idx)
        `TNC_IDX_BATPROT: begin
          batProt_d = merge(batProt_q, wbyte, `TNC_WMASK_BATPROT);
        end
        `TNC_IDX_THERMAL: begin
          thermal_d = merge(thermal_q, wbyte, `TNC_WMASK_THERMAL);
        end
        `TNC_IDX_DERATE: begin
          derate_d = merge(derate_q, wbyte, `TNC_WMASK_DERATE);
        end
        `TNC_IDX_THRESH: begin
          thresh_d = merge(thresh_q, wbyte, `TNC_WMASK_THRESH);
        end
        default: begin
          batProt_d = batProt_q;
        end
      endcase
    end
  end

  // ****************************************
  // apb answer, one wait-free access phase
  // ****************************************
  always @* begin
    prdata_d  = 32'h0000_0000;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (setupPh) begin
      pready_d  = 1'b1;
      pslverr_d = ~mapped(idx);
      case (idx)
        `TNC_IDX_BATPROT: prdata_d = {24'h00_0000, batProt_q};
        `TNC_IDX_RSVD:    prdata_d = {24'h00_0000, `TNC_RST_RSVD};
        `TNC_IDX_THERMAL: prdata_d = {24'h00_0000, thermal_q};
        `TNC_IDX_DERATE:  prdata_d = {24'h00_0000, derate_q};
        `TNC_IDX_THRESH:  prdata_d = {24'h00_0000, thresh_q};
        `TNC_IDX_TSTATUS: prdata_d = {24'h00_0000, 3'h0, goodW, statusW};
        default:          prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // flops
  // ****************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      batProt_q <= `TNC_RST_BATPROT;
      thermal_q <= `TNC_RST_THERMAL;
      derate_q  <= `TNC_RST_DERATE;
      thresh_q  <= `TNC_RST_THRESH;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      wSusp_q   <= 1'b0;
      cSusp_q   <= 1'b0;
      bhotEn_q  <= 1'b1;
    end else begin
      batProt_q <= batProt_d;
      thermal_q <= thermal_d;
      derate_q  <= derate_d;
      thresh_q  <= thresh_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      // suspend when voltage or current code is zero
      wSusp_q   <= (derate_d[`TNC_WVOLT_HI:`TNC_WVOLT_LO] == 3'h0) |
                   (derate_d[`TNC_WCUR_HI:`TNC_WCUR_LO] == 2'h0);
      cSusp_q   <= (derate_d[`TNC_CCUR_HI:`TNC_CCUR_LO] == 2'h0);
      bhotEn_q  <= (thresh_d[`TNC_BHOT_HI:`TNC_BHOT_LO] != `TNC_BHOT_OFF);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  assign discharge_overcurrent_enable = batProt_q[`TNC_BAT_OCP_BIT];
  assign thermal_regulation_threshold = thermal_q[`TNC_TREG_HI:`TNC_TREG_LO];
  assign thermal_shutdown_threshold   = thermal_q[`TNC_TSHUT_HI:`TNC_TSHUT_LO];
  assign input_bus_pulldown_enable    = thermal_q[`TNC_BUSPD_BIT];
  assign adapter1_pulldown_enable     = thermal_q[`TNC_AD1PD_BIT];
  assign adapter2_pulldown_enable     = thermal_q[`TNC_AD2PD_BIT];
  assign warm_voltage_derate          = derate_q[`TNC_WVOLT_HI:`TNC_WVOLT_LO];
  assign warm_current_derate          = derate_q[`TNC_WCUR_HI:`TNC_WCUR_LO];
  assign cool_current_derate          = derate_q[`TNC_CCUR_HI:`TNC_CCUR_LO];
  assign cool_comparator_threshold    = thresh_q[`TNC_CCMP_HI:`TNC_CCMP_LO];
  assign warm_comparator_threshold    = thresh_q[`TNC_WCMP_HI:`TNC_WCMP_LO];
  assign boost_hot_limit              = thresh_q[`TNC_BHOT_HI:`TNC_BHOT_LO];
  assign boost_hot_check_enable       = bhotEn_q;
  assign boost_cold_limit             = thresh_q[`TNC_BOOST_COLD_LIMIT_BIT];
  assign thermistor_bypass            = thresh_q[`TNC_BYPASS_BIT];
  assign warm_charge_suspend          = wSusp_q;
  assign cool_charge_suspend          = cSusp_q;
  assign tempStatus                   = statusW;
  assign tempGood                     = goodW;
  assign chargeAllow                  = chgW;
  assign boostAllow                   = boostW;

endmodule
`default_nettype wire

//--- tnc_config_regs_sva.sv
// assertions on the thermal and thermistor configuration slice
// assumes: bound onto tnc_config_regs, one clock, synchronous reset
`default_nettype none
module tnc_config_regs_sva (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wdExpire,
  input wire logic        regResetReq,
  input wire logic        discharge_overcurrent_enable,
  input wire logic [1:0]  thermal_regulation_threshold,
  input wire logic [1:0]  thermal_shutdown_threshold,
  input wire logic        input_bus_pulldown_enable,
  input wire logic        adapter1_pulldown_enable,
  input wire logic        adapter2_pulldown_enable,
  input wire logic [2:0]  warm_voltage_derate,
  input wire logic [1:0]  warm_current_derate,
  input wire logic [1:0]  cool_current_derate,
  input wire logic [1:0]  boost_hot_limit,
  input wire logic        boost_hot_check_enable,
  input wire logic        boost_cold_limit,
  input wire logic        thermistor_bypass,
  input wire logic        warm_charge_suspend,
  input wire logic        cool_charge_suspend,
  input wire logic [3:0]  tempStatus,
  input wire logic        tempGood
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  chk_bat_wdog: assert property (wdExpire |=> !discharge_overcurrent_enable)
    else $error("overcurrent enable kept after watchdog");
  chk_temp_wdog: assert property (wdExpire |=> thermal_regulation_threshold == 2'h3 && thermal_shutdown_threshold == 2'h0)
    else $error("thermal thresholds not restored");
  chk_pd_keep: assert property (wdExpire && !regResetReq |=> $stable({input_bus_pulldown_enable, adapter1_pulldown_enable, adapter2_pulldown_enable}))
    else $error("pull-down enables lost on watchdog");
  chk_pd_clear: assert property (regResetReq |=> !input_bus_pulldown_enable && !adapter1_pulldown_enable && !adapter2_pulldown_enable)
    else $error("pull-down enables kept after register reset");
  chk_derate_wdog: assert property (wdExpire |=> warm_voltage_derate == 3'h3 && warm_current_derate == 2'h3 && cool_current_derate == 2'h1)
    else $error("derating fields not restored");
  chk_boost_wdog: assert property (wdExpire |=> boost_hot_limit == 2'h1 && !boost_cold_limit && !thermistor_bypass)
    else $error("boost limits not restored");
  chk_hot_off: assert property (boost_hot_check_enable == (boost_hot_limit != 2'h3))
    else $error("hot check enable does not follow limit code");
  chk_susp_code: assert property (warm_charge_suspend == (warm_voltage_derate == 3'h0 || warm_current_derate == 2'h0) && cool_charge_suspend == (cool_current_derate == 2'h0))
    else $error("charge suspend does not follow derate codes");
  chk_bypass_stat: assert property (thermistor_bypass [*2] |-> tempStatus == 4'h0 && tempGood)
    else $error("status not neutral under bypass");
  chk_rsvd_read: assert property (psel && !penable && !pwrite && paddr[7:2] == 6'h15 |=> pready && prdata == 32'h0)
    else $error("reserved register read not zero");
  chk_bad_index: assert property (psel && !penable && paddr[7:2] == 6'h3F |=> pready && pslverr)
    else $error("unmapped index without error");
  cov_wdog: cover property (wdExpire);
  cov_rreset: cover property (regResetReq);
  cov_bypass: cover property (thermistor_bypass [*2]);
endmodule
bind tnc_config_regs tnc_config_regs_sva chk (
  .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdExpire(wdExpire), .regResetReq(regResetReq),
  .discharge_overcurrent_enable(discharge_overcurrent_enable),
  .thermal_regulation_threshold(thermal_regulation_threshold),
  .thermal_shutdown_threshold(thermal_shutdown_threshold),
  .input_bus_pulldown_enable(input_bus_pulldown_enable), .adapter1_pulldown_enable(adapter1_pulldown_enable),
  .adapter2_pulldown_enable(adapter2_pulldown_enable), .warm_voltage_derate(warm_voltage_derate),
  .warm_current_derate(warm_current_derate), .cool_current_derate(cool_current_derate),
  .boost_hot_limit(boost_hot_limit), .boost_hot_check_enable(boost_hot_check_enable),
  .boost_cold_limit(boost_cold_limit), .thermistor_bypass(thermistor_bypass),
  .warm_charge_suspend(warm_charge_suspend), .cool_charge_suspend(cool_charge_suspend),
  .tempStatus(tempStatus), .tempGood(tempGood)
);
`default_nettype wire

//--- tnc_regs_map.vh
// constants for the thermal and thermistor configuration slice
// assumes: included by bare name from tnc_*.v design files
//
// What this block does
// - control bit 0 enables discharge over-current protection, default off, watchdog clears it
// - bits 5-4 pick shutdown threshold 150/130/120/85 C, default code 0
// - bit 3 enables input bus pull-down, cleared by register reset only
// - bits 2 and 1 enable adapter pull-downs, cleared by register reset only
// - bits 7-5 warm voltage derate, 0 suspends, 7 unchanged, default 011b
// - bits 4-3 warm current derate suspend/20/40/unchanged, default 11b
// - bits 2-1 cool current derate, same encoding, default 01b
// - bits 7-6 cool comparator rising threshold, default code 1
// - bits 5-4 warm comparator falling threshold, default code 1
// - bits 3-2 boost hot limit 55/60/65 C or disabled, default code 1
// - boost cold limit bit, 0 is minus 10 C, 1 is minus 20 C
// - thermistor bypass forces sense good, allows charge and boost, status 0000
// - derating and threshold registers return to defaults on watchdog expiry
`ifndef TNC_REGS_MAP_VH
`define TNC_REGS_MAP_VH

// ****************************************
// register indexes, byte address is 4x
// ****************************************
`define TNC_IDX_BATPROT   6'h14
`define TNC_IDX_RSVD      6'h15
`define TNC_IDX_THERMAL   6'h16
`define TNC_IDX_DERATE    6'h17
`define TNC_IDX_THRESH    6'h18
`define TNC_IDX_TSTATUS   6'h20

// ****************************************
// field positions
// ****************************************
`define TNC_BAT_OCP_BIT   0
`define TNC_TREG_HI       7
`define TNC_TREG_LO       6
`define TNC_TSHUT_HI      5
`define TNC_TSHUT_LO      4
`define TNC_BUSPD_BIT     3
`define TNC_AD1PD_BIT     2
`define TNC_AD2PD_BIT     1
`define TNC_WVOLT_HI      7
`define TNC_WVOLT_LO      5
`define TNC_WCUR_HI       4
`define TNC_WCUR_LO       3
`define TNC_CCUR_HI       2
`define TNC_CCUR_LO       1
`define TNC_CCMP_HI       7
`define TNC_CCMP_LO       6
`define TNC_WCMP_HI       5
`define TNC_WCMP_LO       4
`define TNC_BHOT_HI       3
`define TNC_BHOT_LO       2
`define TNC_BOOST_COLD_LIMIT_BIT     1
`define TNC_BYPASS_BIT    0

// ****************************************
// reset values and masks
// ****************************************
`define TNC_RST_BATPROT   8'h00
`define TNC_RST_RSVD      8'h00
`define TNC_RST_THERMAL   8'hC0
`define TNC_RST_DERATE    8'h7A
`define TNC_RST_THRESH    8'h54
`define TNC_WMASK_BATPROT 8'h01
`define TNC_WMASK_THERMAL 8'hFE
`define TNC_WMASK_DERATE  8'hFE
`define TNC_WMASK_THRESH  8'hFF
`define TNC_WDOG_BATPROT  8'h01
`define TNC_WDOG_THERMAL  8'hF0
`define TNC_WDOG_DERATE   8'hFE
`define TNC_WDOG_THRESH   8'hFF
`define TNC_BHOT_OFF      2'h3

`endif

//--- tnc_sync2.v
// two flip-flop synchroniser for asynchronous level inputs
// assumes: inputs are slow levels from comparator pins
`default_nettype none

module tnc_sync2 #(
  parameter W = 4
) (
  input  wire         core_clk,
  input  wire         rstn,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  // ****************************************
  // synchroniser stages
  // ****************************************
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge core_clk) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule
`default_nettype wire

//--- tnc_tb.sv
// self-checking bench for the configuration register slice
// assumes: tnc_config_regs and its checker compiled before it
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0;
  logic        rstn = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        wdExpire = 1'h0, regResetReq = 1'h0;
  logic        coldCmpPin = 1'h0, coolCmpPin = 1'h0, warmCmpPin = 1'h0, hotCmpPin = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, discharge_overcurrent_enable, input_bus_pulldown_enable;
  logic        adapter1_pulldown_enable, adapter2_pulldown_enable, boost_hot_check_enable;
  logic        boost_cold_limit, thermistor_bypass, warm_charge_suspend, cool_charge_suspend;
  logic        tempGood, chargeAllow, boostAllow;
  logic [1:0]  thermal_regulation_threshold, thermal_shutdown_threshold, warm_current_derate;
  logic [1:0]  cool_current_derate, cool_comparator_threshold, warm_comparator_threshold;
  logic [1:0]  boost_hot_limit;
  logic [2:0]  warm_voltage_derate;
  logic [3:0]  tempStatus;
  int          fails = 0, checks_done = 0;
  logic [5:0]  idxT [5] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h18};
  logic [7:0]  mskT [5] = '{8'h01, 8'h00, 8'hFE, 8'hFE, 8'hFF};
  logic [7:0]  rstT [5] = '{8'h00, 8'h00, 8'hC0, 8'h7A, 8'h54};
  logic [7:0]  wdgT [5] = '{8'h00, 8'h00, 8'hCE, 8'h7A, 8'h54};

  tnc_config_regs DUT (
    .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdExpire(wdExpire), .regResetReq(regResetReq), .coldCmpPin(coldCmpPin), .coolCmpPin(coolCmpPin),
    .warmCmpPin(warmCmpPin), .hotCmpPin(hotCmpPin),
    .discharge_overcurrent_enable(discharge_overcurrent_enable),
    .thermal_regulation_threshold(thermal_regulation_threshold),
    .thermal_shutdown_threshold(thermal_shutdown_threshold),
    .input_bus_pulldown_enable(input_bus_pulldown_enable), .adapter1_pulldown_enable(adapter1_pulldown_enable),
    .adapter2_pulldown_enable(adapter2_pulldown_enable), .warm_voltage_derate(warm_voltage_derate),
    .warm_current_derate(warm_current_derate), .cool_current_derate(cool_current_derate),
    .cool_comparator_threshold(cool_comparator_threshold),
    .warm_comparator_threshold(warm_comparator_threshold),
    .boost_hot_limit(boost_hot_limit), .boost_hot_check_enable(boost_hot_check_enable),
    .boost_cold_limit(boost_cold_limit), .thermistor_bypass(thermistor_bypass),
    .warm_charge_suspend(warm_charge_suspend), .cool_charge_suspend(cool_charge_suspend),
    .tempStatus(tempStatus), .tempGood(tempGood), .chargeAllow(chargeAllow), .boostAllow(boostAllow)
  );

  // ****************************************
  // clock, watchdog, tasks
  // ****************************************
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    xfer(idx, 1'h1, d, rd, e);
  endtask
  task automatic rdChk(input logic [5:0] idx, input logic [7:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        e;
    xfer(idx, 1'h0, 8'h00, rd, e);
    check(rd, {24'h0, exp});
    check(32'(e), 32'(expErr));
  endtask
  task automatic pulse(input int which);
    if (which == 0) wdExpire <= 1'h1;
    else regResetReq <= 1'h1;
    @(posedge core_clk);
    wdExpire <= 1'h0;
    regResetReq <= 1'h0;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] v;
    logic [6:0] st;
    repeat (16) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) rdChk(idxT[i], rstT[i], 1'h0);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      v = {k[2:0], k[1:0], k[2:0]};
      {hotCmpPin, warmCmpPin, coolCmpPin, coldCmpPin} <= {k[1], k[2], k[2] ^ k[1], k[2]};
      st = v[0] ? 7'h07 : {k[1], k[2], k[2] ^ k[1], k[2], {3{!(k[1] | k[2])}}};
      for (int i = 0; i < 5; i++) wr(idxT[i], v);
      for (int i = 0; i < 5; i++) rdChk(idxT[i], v & mskT[i], 1'h0);
      check(32'({discharge_overcurrent_enable, input_bus_pulldown_enable, adapter1_pulldown_enable,
                 adapter2_pulldown_enable}), 32'({v[0], v[3:1]}));
      check(32'({thermal_regulation_threshold, thermal_shutdown_threshold, warm_voltage_derate,
                 warm_current_derate, cool_current_derate}), 32'({v[7:4], v[7:1]}));
      check(32'({cool_comparator_threshold, warm_comparator_threshold, boost_hot_limit, boost_cold_limit,
                 thermistor_bypass, boost_hot_check_enable}), 32'({v, v[3:2] != 2'h3}));
      check(32'({warm_charge_suspend, cool_charge_suspend}),
            32'({v[7:5] == 3'h0 || v[4:3] == 2'h0, v[2:1] == 2'h0}));
      check(32'({tempStatus, tempGood, chargeAllow, boostAllow}), 32'(st));
      rdChk(6'h20, {3'h0, st[2], st[6:3]}, 1'h0);
    end
    $display("test field codes done");
    for (int i = 0; i < 5; i++) wr(idxT[i], 8'hFF);
    pulse(0);
    for (int i = 0; i < 5; i++) rdChk(idxT[i], wdgT[i], 1'h0);
    $display("test watchdog done");
    pulse(1);
    for (int i = 0; i < 5; i++) rdChk(idxT[i], rstT[i], 1'h0);
    wr(6'h3F, 8'hFF);
    rdChk(6'h3F, 8'h00, 1'h1);
    $display("test register reset done");
    finish_test();
  end
endmodule
`default_nettype wire

//--- tnc_temp_status.v
// thermistor range status with bypass override
// assumes: comparator flags already synchronised to core_clk
`include "tnc_regs_map.vh"
`default_nettype none

module tnc_temp_status (
  input  wire       core_clk,
  input  wire       rstn,
  input  wire [3:0] rangeFlags,
  input  wire       bypass,
  output wire [3:0] tempStatus,
  output wire       tempGood,
  output wire       chargeAllow,
  output wire       boostAllow
);

  // ****************************************
  // status, flags are cold, cool, warm, hot
  // ****************************************
  reg [3:0] status_q;
  reg       good_q;
  reg       chg_q;
  reg       boost_q;

  always @(posedge core_clk) begin
    if (!rstn) begin
      status_q <= 4'h0;
      good_q   <= 1'b1;
      chg_q    <= 1'b1;
      boost_q  <= 1'b1;
    end else if (bypass) begin
      status_q <= 4'h0;
      good_q   <= 1'b1;
      chg_q    <= 1'b1;
      boost_q  <= 1'b1;
    end else begin
      status_q <= rangeFlags;
      good_q   <= ~(rangeFlags[0] | rangeFlags[3]);
      chg_q    <= ~(rangeFlags[0] | rangeFlags[3]);
      boost_q  <= ~(rangeFlags[0] | rangeFlags[3]);
    end
  end

  assign tempStatus  = status_q;
  assign tempGood    = good_q;
  assign chargeAllow = chg_q;
  assign boostAllow  = boost_q;

endmodule
`default_nettype wire
